// ---- hdl/acc_pkg.sv ----
// package: register layout, start sources, state codes and timing for converter control
package acc_pkg;
  // ***************
  // register layout
  // ***************
  localparam logic [7:0] ACC_CSR_ADDR    = 8'hE8;
  localparam logic [7:0] ACC_CSR_RESET   = 8'h00;
  localparam int         ACC_BIT_ENABLE  = 7;
  localparam int         ACC_BIT_TRACK   = 6;
  localparam int         ACC_BIT_DONE    = 5;
  localparam int         ACC_BIT_BUSY    = 4;
  localparam int         ACC_BIT_WINDOW  = 3;
  localparam int         ACC_SRC_MSB     = 2;
  localparam int         ACC_SRC_LSB     = 0;

  // ***************
  // start sources
  // ***************
  localparam logic [2:0] ACC_SRC_BUSY_WR = 3'h0;
  localparam logic [2:0] ACC_SRC_TIMER3  = 3'h5;

  // ***************
  // timing, in converter clocks and mclk cycles
  // ***************
  localparam int         ACC_TRACK_SAR   = 3;
  localparam int         ACC_CONV_SAR    = 11;
  localparam int         ACC_SAR_DIV     = 4;
  localparam int         ACC_TRACK_CYC   = ACC_TRACK_SAR * ACC_SAR_DIV;
  localparam int         ACC_CONV_CYC    = ACC_CONV_SAR * ACC_SAR_DIV;

  typedef enum logic [1:0] {
    ACC_OFF   = 2'b00,
    ACC_IDLE  = 2'b01,
    ACC_TRACK = 2'b11,
    ACC_CONV  = 2'b10
  } acc_state_e;
endpackage : acc_pkg

// ---- hdl/acc_conv_ctrl.sv ----
// converter control and status register with conversion sequencer
// Operation
// - enable clear holds converter in shutdown, no tracking or conversion
// - normal track mode tracks continuously except during conversion
// - low-power track mode tracks only when the start source fires
// - done flag reads zero until a conversion finishes or is aborted after clearing
// - busy bit reads one for the whole conversion
// - done flag sets on the falling edge of busy
// - low-power mode begins each conversion with three converter clocks tracking
// - source 101 starts on timer 3 overflow; 11x reserved
// - window flag sets when the result meets the window condition
module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int TRACK_CYC = acc_pkg::ACC_TRACK_CYC,
  parameter int CONV_CYC  = acc_pkg::ACC_CONV_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       bit_wr,
  input  wire logic [2:0] bit_sel,
  input  wire logic       bit_val,
  output logic      [7:0] sfr_rdata,
  input  wire logic       timer3_ovf,
  input  wire logic       window_hit,
  output logic            sar_converter_power,
  output logic            sar_converter_track,
  output logic            sar_converter_convert,
  output logic            sar_converter_done
);
  import acc_pkg::*;

  // ***************
  // register file
  // ***************
  logic       converter_enable_q;
  logic       track_mode_select_q;
  logic       conversion_done_flag_q;
  logic       window_match_flag_q;
  logic [2:0] start_source_select_q;
  logic       conversion_busy_q;
  acc_state_e state_q;
  logic [7:0] cnt_q;
  logic       csr_sel;
  logic [7:0] wr_mask;
  logic [7:0] wr_val;
  logic       start_req;
  logic       busy_fall;

  // ***************
  // helpers
  // ***************
  // one decode shared by the busy bit and its falling-edge detector
  function automatic logic acc_busy_state(input acc_state_e s);
    return (s == ACC_TRACK) || (s == ACC_CONV);
  endfunction : acc_busy_state

  // byte write or single-bit write of the bit-addressable register
  assign csr_sel = (sfr_addr == ACC_CSR_ADDR);
  always_comb begin
    wr_mask = 8'h00;
    wr_val  = sfr_wdata;
    if (csr_sel && sfr_wr) begin
      wr_mask = 8'hFF;
    end else if (csr_sel && bit_wr) begin
      wr_mask = 8'h01 << bit_sel;
      wr_val  = {8{bit_val}};
    end
  end

  // busy is a command here, not a stored bit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      converter_enable_q    <= 1'b0;
      track_mode_select_q   <= 1'b0;
      start_source_select_q <= 3'h0;
    end else begin
      if (wr_mask[ACC_BIT_ENABLE]) begin
        converter_enable_q <= wr_val[ACC_BIT_ENABLE];
      end
      if (wr_mask[ACC_BIT_TRACK]) begin
        track_mode_select_q <= wr_val[ACC_BIT_TRACK];
      end
      for (int i = ACC_SRC_LSB; i <= ACC_SRC_MSB; i++) begin
        if (wr_mask[i]) begin
          start_source_select_q[i] <= wr_val[i];
        end
      end
    end
  end

  // ***************
  // start request
  // ***************
  // only acted on in idle, so a start while busy is dropped
  always_comb begin
    case (start_source_select_q)
      ACC_SRC_BUSY_WR: start_req = wr_mask[ACC_BIT_BUSY] && wr_val[ACC_BIT_BUSY];
      ACC_SRC_TIMER3:  start_req = timer3_ovf;
      default:         start_req = 1'b0; // other sources not wired here; 11x reserved
    endcase
  end

  // ***************
  // sequencer
  // ***************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= ACC_OFF;
      cnt_q   <= 8'h00;
    end else if (!converter_enable_q) begin
      // an abort still drops busy, so the done flag sets as well
      state_q <= ACC_OFF;
      cnt_q   <= 8'h00;
    end else begin
      case (state_q)
        ACC_OFF: begin
          state_q <= ACC_IDLE;
        end
        ACC_IDLE: begin
          if (start_req && track_mode_select_q) begin
            state_q <= ACC_TRACK;
            cnt_q   <= 8'(TRACK_CYC - 1);
          end else if (start_req) begin
            state_q <= ACC_CONV;
            cnt_q   <= 8'(CONV_CYC - 1);
          end
        end
        ACC_TRACK: begin
          if (cnt_q == 8'h00) begin
            state_q <= ACC_CONV;
            cnt_q   <= 8'(CONV_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ACC_CONV: begin
          if (cnt_q == 8'h00) begin
            state_q <= ACC_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= ACC_OFF;
        end
      endcase
    end
  end

  // ***************
  // status flags
  // ***************
  // busy covers the low-power tracking phase too, so software sees one span
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      conversion_busy_q <= 1'b0;
    end else begin
      conversion_busy_q <= acc_busy_state(state_q);
    end
  end

  assign busy_fall = conversion_busy_q && !acc_busy_state(state_q);

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      conversion_done_flag_q <= 1'b0;
    end else if (busy_fall) begin
      conversion_done_flag_q <= 1'b1;
    end else if (wr_mask[ACC_BIT_DONE]) begin
      conversion_done_flag_q <= wr_val[ACC_BIT_DONE];
    end
  end

  // the compare lives outside; only its verdict is sampled at busy fall
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      window_match_flag_q <= 1'b0;
    end else if (busy_fall && window_hit) begin
      window_match_flag_q <= 1'b1;
    end else if (wr_mask[ACC_BIT_WINDOW]) begin
      window_match_flag_q <= wr_val[ACC_BIT_WINDOW];
    end
  end

  // ***************
  // read path
  // ***************
  // registered read: data follows the address one cycle later
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sfr_rdata <= ACC_CSR_RESET;
    end else begin
      sfr_rdata <= csr_sel ? {converter_enable_q, track_mode_select_q,
                              conversion_done_flag_q, conversion_busy_q,
                              window_match_flag_q, start_source_select_q} : 8'h00;
    end
  end

  // ***************
  // converter drive
  // ***************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sar_converter_power   <= 1'b0;
      sar_converter_track   <= 1'b0;
      sar_converter_convert <= 1'b0;
      sar_converter_done    <= 1'b0;
    end else begin
      sar_converter_power   <= converter_enable_q;
      sar_converter_track   <= converter_enable_q &&
                               ((state_q == ACC_TRACK) ||
                                (!track_mode_select_q && state_q == ACC_IDLE));
      // gated by enable so a shutdown cuts a running conversion at once
      sar_converter_convert <= converter_enable_q && (state_q == ACC_CONV);
      sar_converter_done    <= busy_fall;
    end
  end
endmodule : acc_conv_ctrl

// ---- bench/acc_conv_ctrl_asserts.sv ----
// checker: output timing of the converter control block
module acc_conv_ctrl_asserts
  import acc_pkg::*;
#(
  parameter int TRACK_CYC = acc_pkg::ACC_TRACK_CYC,
  parameter int CONV_CYC  = acc_pkg::ACC_CONV_CYC
) (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sar_converter_power,
  input wire logic       sar_converter_track,
  input wire logic       sar_converter_convert,
  input wire logic       sar_converter_done
);
  wire p = sar_converter_power;
  wire t = sar_converter_track;
  wire c = sar_converter_convert;
  wire d = sar_converter_done;
  logic [7:0] t_len_q;
  logic [7:0] c_len_q;
  // run lengths in counters, since repeat counts must stay small
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      t_len_q <= 8'h00;
    end else if (t) begin
      t_len_q <= t_len_q + 8'h01;
    end else begin
      t_len_q <= 8'h00;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      c_len_q <= 8'h00;
    end else if (c) begin
      c_len_q <= c_len_q + 8'h01;
    end else begin
      c_len_q <= 8'h00;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_off_quiet: assert property (!p |-> !t && !c) else $error("active while off");
  a_enable_wr: assert property (sfr_wr && sfr_addr == ACC_CSR_ADDR &&
                                sfr_wdata[ACC_BIT_ENABLE] |-> ##[1:2] p)
    else $error("no power after enable");
  a_track_excl: assert property (!(t && c)) else $error("track during convert");
  a_conv_len: assert property ($fell(c) && p |-> c_len_q == 8'(CONV_CYC))
    else $error("bad length");
  a_done_fall: assert property ($fell(c) && p |-> ##[0:1] d) else $error("no done");
  a_done_pulse: assert property (d |=> !d) else $error("done too long");
  a_done_cause: assert property (d |-> $past(c) || $past(c, 2)) else $error("stray done");
  a_conv_pwr: assert property (c |-> p) else $error("convert while off");
  cover property ($fell(c));
  cover property ($fell(t) && t_len_q == 8'(TRACK_CYC));
  cover property (d);
endmodule : acc_conv_ctrl_asserts

bind acc_conv_ctrl acc_conv_ctrl_asserts #(.TRACK_CYC(TRACK_CYC), .CONV_CYC(CONV_CYC)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sar_converter_power(sar_converter_power), .sar_converter_track(sar_converter_track),
  .sar_converter_convert(sar_converter_convert), .sar_converter_done(sar_converter_done));

// ---- bench/test_adc_conversion_control.sv ----
// testbench: register driven checks of the converter control block
module test_adc_conversion_control;
  timeunit 1ns;
  timeprecision 1ns;
  import acc_pkg::*;
  logic       mclk = 0, rst_n = 0, sfr_wr = 0, bit_wr = 0, bit_val = 0, tov = 0, whit = 1;
  logic [7:0] sfr_addr = 8'hE8, sfr_wdata = 8'h00, rdata;
  logic [2:0] bit_sel = 3'h0;
  logic       p, t, c, d;
  int         err_total = 0, n_compared = 0, cyc = 0, nt, nc, nd;
  // shortened counts keep the run brief
  acc_conv_ctrl #(.TRACK_CYC(2), .CONV_CYC(3)) dut_u (.mclk(mclk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .bit_wr(bit_wr),
    .bit_sel(bit_sel), .bit_val(bit_val), .sfr_rdata(rdata), .timer3_ovf(tov),
    .window_hit(whit), .sar_converter_power(p), .sar_converter_track(t),
    .sar_converter_convert(c), .sar_converter_done(d));
  initial forever #2 mclk = ~mclk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    sfr_addr = a;
    @(negedge mclk);
    chk(rdata, exp);
  endtask : rd
  task automatic bw(input logic [2:0] s, input logic v);
    @(negedge mclk);
    bit_sel = s;
    bit_val = v;
    bit_wr = 1'b1;
    @(negedge mclk);
    bit_wr = 1'b0;
  endtask : bw
  task automatic tp;
    @(negedge mclk);
    tov = 1'b1;
    @(negedge mclk);
    tov = 1'b0;
  endtask : tp
  // sample first: the start edge has already passed when this is entered
  task automatic run;
    nt = 0;
    nc = 0;
    nd = 0;
    repeat (40) begin
      nt += t;
      nc += c;
      if (d === 1'b1) begin
        nd = 1;
        break;
      end
      @(negedge mclk);
    end
  endtask : run
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    rd(8'hE8, 8'h00);
    wr(8'hE8, 8'h80);
    repeat (2) @(negedge mclk);
    chk(t, 1'b1);
    chk(p, 1'b1);
    wr(8'hE8, 8'h90);
    run();
    chk(nc[7:0], 8'h03);
    chk(nd[7:0], 8'h01);
    rd(8'hE8, 8'hA8);
    bw(3'h4, 1'b0);
    run();
    chk(nc[7:0], 8'h00);
    bw(3'h5, 1'b0);
    rd(8'hE8, 8'h88);
    wr(8'hE8, 8'h90);
    repeat (2) @(negedge mclk);
    chk(rdata[4], 1'b1);
    run();
    chk(nd[7:0], 8'h01);
    $display("test normal done");
    wr(8'hE8, 8'hC5);
    repeat (2) @(negedge mclk);
    chk(t, 1'b0);
    whit = 1'b0;
    tp();
    run();
    chk(nt[7:0], 8'h02);
    chk(nc[7:0], 8'h03);
    rd(8'hE8, 8'hE5);
    $display("test low power done");
    wr(8'hE8, 8'hC6);
    repeat (2) @(negedge mclk);
    tp();
    run();
    chk(nc[7:0], 8'h00);
    chk(nd[7:0], 8'h00);
    rd(8'hE8, 8'hC6);
    $display("test reserved done");
    wr(8'hE8, 8'h00);
    wr(8'hE8, 8'h10);
    run();
    chk(nc[7:0], 8'h00);
    chk(p, 1'b0);
    rd(8'h10, 8'h00);
    $display("test shutdown done");
    final_report();
  end
endmodule : test_adc_conversion_control
